// ===== rtl/lmdp_regs.sv
// AXI4-Lite register bank: battery and feed current sense, converter period.
// Assumes sense codes synchronous to aclk and one outstanding access per direction.
`timescale 1ns/100ps
`include "lmdp_defs.svh"

module lmdp_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address channel
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data channel
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Measurement codes from the analog sense path
  input  wire logic [7:0]  batt_a_in,
  input  wire logic [7:0]  batt_b_in,
  input  wire logic [7:0]  feed_one_in,
  input  wire logic [7:0]  feed_two_in,
  input  wire logic [7:0]  feed_three_in,
  input  wire logic [7:0]  feed_four_in,
  input  wire logic [7:0]  feed_five_in,
  input  wire logic [7:0]  feed_six_in,
  input  wire logic [7:0]  extended_battery_offset_current,
  // Converter controls
  output logic [7:0]       converter_pwm_period,
  output logic             converter_period_start,
  output logic             extended_battery_enable
);

  // Write path state
  lmdp_pkg::lmdp_wr_state_t wr_state_ff;  // Which halves of a write are held
  lmdp_pkg::lmdp_wr_state_t nxt_wr_state;
  logic [11:0]              wr_addr_ff;   // Held write address
  logic [31:0]              wr_data_ff;   // Held write data
  logic [3:0]               wr_strb_ff;   // Held byte enables

  // Software controlled registers
  logic [7:0]               pwm_period_ff; // Bit 6 is never stored as zero
  logic                     ext_en_ff;     // Extended battery enable

  // Bus output registers
  logic                     awready_ff;
  logic                     wready_ff;
  logic                     bvalid_ff;
  logic [1:0]               bresp_ff;
  logic                     arready_ff;
  logic                     rvalid_ff;
  logic [31:0]              rdata_ff;
  logic [1:0]               rresp_ff;

  // Live sense copies
  logic [7:0]               batt_a_q;
  logic [7:0]               batt_b_q;
  logic [7:0]               feed_one_q;
  logic [7:0]               feed_two_q;
  logic [7:0]               feed_three_q;
  logic [7:0]               feed_four_q;
  logic [7:0]               feed_five_q;
  logic [7:0]               feed_six_q;

  // Handshake and decode wires
  wire logic                aw_fire;
  wire logic                w_fire;
  wire logic                ar_fire;
  wire logic                have_addr;
  wire logic                have_data;
  wire logic                wr_commit;
  wire lmdp_pkg::lmdp_idx_t wr_idx;
  wire lmdp_pkg::lmdp_idx_t rd_idx;
  wire logic                wr_in_range;
  wire logic                rd_in_range;
  wire logic                wr_hit_pwm;
  wire logic                wr_hit_ext;
  wire logic                wr_hit_ro;
  wire logic                rd_hit;
  wire logic [7:0]          rd_byte;
  wire logic [7:0]          pwm_read;
  wire logic [7:0]          nxt_pwm_period;

  // Sense capture, with the extended battery share taken out of feed one and two
  lmdp_sense_snap u_snap (
    .aclk                            (aclk),
    .aresetn                         (aresetn),
    .extended_battery_enable         (ext_en_ff),
    .extended_battery_offset_current (extended_battery_offset_current),
    .batt_a_in                       (batt_a_in),
    .batt_b_in                       (batt_b_in),
    .feed_one_in                     (feed_one_in),
    .feed_two_in                     (feed_two_in),
    .feed_three_in                   (feed_three_in),
    .feed_four_in                    (feed_four_in),
    .feed_five_in                    (feed_five_in),
    .feed_six_in                     (feed_six_in),
    .batt_a_ff                       (batt_a_q),
    .batt_b_ff                       (batt_b_q),
    .feed_one_ff                     (feed_one_q),
    .feed_two_ff                     (feed_two_q),
    .feed_three_ff                   (feed_three_q),
    .feed_four_ff                    (feed_four_q),
    .feed_five_ff                    (feed_five_q),
    .feed_six_ff                     (feed_six_q)
  );

  // Period timer driven by the stored code
  lmdp_pwm_timer u_timer (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .period_code     (pwm_read),
    .period_start_ff (converter_period_start)
  );

  // Channel handshakes
  assign aw_fire   = s_axi_awvalid && awready_ff;
  assign w_fire    = s_axi_wvalid && wready_ff;
  assign ar_fire   = s_axi_arvalid && arready_ff;
  assign have_addr = (wr_state_ff == lmdp_pkg::LMDP_WR_ADDR) || aw_fire;
  assign have_data = (wr_state_ff == lmdp_pkg::LMDP_WR_DATA) || w_fire;
  assign wr_commit = (wr_state_ff != lmdp_pkg::LMDP_WR_RESP) && have_addr && have_data;

  // Address decode; the top bits above the index must be zero
  assign wr_idx      = wr_state_ff == lmdp_pkg::LMDP_WR_ADDR ?
                       wr_addr_ff[`LMDP_IDX_MSB:`LMDP_IDX_LSB] :
                       s_axi_awaddr[`LMDP_IDX_MSB:`LMDP_IDX_LSB];
  assign wr_in_range = wr_state_ff == lmdp_pkg::LMDP_WR_ADDR ?
                       (wr_addr_ff[11:10] == 2'h0) : (s_axi_awaddr[11:10] == 2'h0);
  assign rd_idx      = s_axi_araddr[`LMDP_IDX_MSB:`LMDP_IDX_LSB];
  assign rd_in_range = (s_axi_araddr[11:10] == 2'h0);

  assign wr_hit_pwm = wr_in_range && (wr_idx == `LMDP_IDX_PWM_PERIOD);
  assign wr_hit_ext = wr_in_range && (wr_idx == `LMDP_IDX_EXT_CTRL);
  assign wr_hit_ro  = wr_in_range && (wr_idx >= `LMDP_IDX_BATT_A) && (wr_idx <= `LMDP_IDX_FEED_SIX);

  // Bit 6 is read as one regardless of what was written
  assign pwm_read = pwm_period_ff | (8'h01 << `LMDP_PWM_FIXED_BIT);

  // Merge the written byte; bit 6 keeps its forced value
  assign nxt_pwm_period = (pwm_period_ff & ~`LMDP_PWM_WR_MASK) |
                          ((have_data && wr_state_ff != lmdp_pkg::LMDP_WR_DATA ? s_axi_wdata[7:0] :
                            wr_data_ff[7:0]) & `LMDP_PWM_WR_MASK);

  // Read mux; selecting a value never disturbs it
  assign rd_byte = (rd_idx == `LMDP_IDX_BATT_A)     ? batt_a_q     :
                   (rd_idx == `LMDP_IDX_BATT_B)     ? batt_b_q     :
                   (rd_idx == `LMDP_IDX_FEED_ONE)   ? feed_one_q   :
                   (rd_idx == `LMDP_IDX_FEED_TWO)   ? feed_two_q   :
                   (rd_idx == `LMDP_IDX_FEED_THREE) ? feed_three_q :
                   (rd_idx == `LMDP_IDX_FEED_FOUR)  ? feed_four_q  :
                   (rd_idx == `LMDP_IDX_FEED_FIVE)  ? feed_five_q  :
                   (rd_idx == `LMDP_IDX_FEED_SIX)   ? feed_six_q   :
                   (rd_idx == `LMDP_IDX_PWM_PERIOD) ? pwm_read     :
                   (rd_idx == `LMDP_IDX_EXT_CTRL)   ? {7'h00, ext_en_ff} : 8'h00;
  assign rd_hit  = rd_in_range && ((rd_idx >= `LMDP_IDX_BATT_A && rd_idx <= `LMDP_IDX_FEED_SIX) ||
                                   rd_idx == `LMDP_IDX_PWM_PERIOD || rd_idx == `LMDP_IDX_EXT_CTRL);

  // Write sequencing: address and data may come in either order
  always_comb begin
    nxt_wr_state = wr_state_ff;
    case (wr_state_ff)
      lmdp_pkg::LMDP_WR_IDLE: begin
        if (aw_fire && w_fire) begin
          nxt_wr_state = lmdp_pkg::LMDP_WR_RESP;
        end else if (aw_fire) begin
          nxt_wr_state = lmdp_pkg::LMDP_WR_ADDR;
        end else if (w_fire) begin
          nxt_wr_state = lmdp_pkg::LMDP_WR_DATA;
        end
      end
      lmdp_pkg::LMDP_WR_ADDR: begin
        if (w_fire) begin
          nxt_wr_state = lmdp_pkg::LMDP_WR_RESP;
        end
      end
      lmdp_pkg::LMDP_WR_DATA: begin
        if (aw_fire) begin
          nxt_wr_state = lmdp_pkg::LMDP_WR_RESP;
        end
      end
      lmdp_pkg::LMDP_WR_RESP: begin
        if (s_axi_bready) begin
          nxt_wr_state = lmdp_pkg::LMDP_WR_IDLE;
        end
      end
      default: begin
        nxt_wr_state = lmdp_pkg::LMDP_WR_IDLE;
      end
    endcase
  end

  // Write channel registers; ready drops once its half is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= lmdp_pkg::LMDP_WR_IDLE;
      awready_ff  <= 1'b0;
      wready_ff   <= 1'b0;
      wr_addr_ff  <= 12'h000;
      wr_data_ff  <= 32'h0000_0000;
      wr_strb_ff  <= 4'h0;
    end else begin
      wr_state_ff <= nxt_wr_state;
      awready_ff  <= (nxt_wr_state == lmdp_pkg::LMDP_WR_IDLE) || (nxt_wr_state == lmdp_pkg::LMDP_WR_DATA);
      wready_ff   <= (nxt_wr_state == lmdp_pkg::LMDP_WR_IDLE) || (nxt_wr_state == lmdp_pkg::LMDP_WR_ADDR);
      if (aw_fire) begin
        wr_addr_ff <= s_axi_awaddr;
      end
      if (w_fire) begin
        wr_data_ff <= s_axi_wdata;
        wr_strb_ff <= s_axi_wstrb;
      end
    end
  end

  // Register updates and write answer; unmapped writes get an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_period_ff <= `LMDP_PWM_RESET;
      ext_en_ff     <= `LMDP_EXT_RESET;
      bvalid_ff     <= 1'b0;
      bresp_ff      <= `LMDP_RESP_OKAY;
    end else begin
      if (wr_commit) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wr_hit_pwm || wr_hit_ext || wr_hit_ro) ? `LMDP_RESP_OKAY : `LMDP_RESP_SLVERR;
        // Only byte lane 0 carries register data
        if (wr_hit_pwm && ((w_fire ? s_axi_wstrb[0] : wr_strb_ff[0]))) begin
          pwm_period_ff <= nxt_pwm_period;
        end
        if (wr_hit_ext && ((w_fire ? s_axi_wstrb[0] : wr_strb_ff[0]))) begin
          ext_en_ff <= w_fire ? s_axi_wdata[`LMDP_EXT_EN_BIT] : wr_data_ff[`LMDP_EXT_EN_BIT];
        end
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel; one read in flight, data held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `LMDP_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        // Unmapped places answer zero data, whatever the index bits below them decode to
        rdata_ff   <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        rresp_ff   <= rd_hit ? `LMDP_RESP_OKAY : `LMDP_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end else if (!rvalid_ff) begin
        arready_ff <= 1'b1;
      end
    end
  end

  // Ports straight from flip-flops
  assign s_axi_awready           = awready_ff;
  assign s_axi_wready            = wready_ff;
  assign s_axi_bvalid            = bvalid_ff;
  assign s_axi_bresp             = bresp_ff;
  assign s_axi_arready           = arready_ff;
  assign s_axi_rvalid            = rvalid_ff;
  assign s_axi_rdata             = rdata_ff;
  assign s_axi_rresp             = rresp_ff;
  assign converter_pwm_period    = pwm_period_ff;
  assign extended_battery_enable = ext_en_ff;

endmodule : lmdp_regs

// ===== rtl/lmdp_defs.svh
// Offsets, field positions, reset values and timing counts of the line monitor bank.
// Assumes inclusion by bare name from rtl files; definitions only.
`ifndef LMDP_DEFS_SVH
`define LMDP_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define LMDP_IDX_BATT_A      8'h52
`define LMDP_IDX_BATT_B      8'h53
`define LMDP_IDX_FEED_ONE    8'h54
`define LMDP_IDX_FEED_TWO    8'h55
`define LMDP_IDX_FEED_THREE  8'h56
`define LMDP_IDX_FEED_FOUR   8'h57
`define LMDP_IDX_FEED_FIVE   8'h58
`define LMDP_IDX_FEED_SIX    8'h59
`define LMDP_IDX_PWM_PERIOD  8'h5c
`define LMDP_IDX_EXT_CTRL    8'h5f

// Bus geometry
`define LMDP_ADDR_W          12
`define LMDP_IDX_LSB         2
`define LMDP_IDX_MSB         9

// Converter period register: bit 6 reads one, the rest is stored
`define LMDP_PWM_FIXED_BIT   6
`define LMDP_PWM_RESET       8'hff
`define LMDP_PWM_WR_MASK     8'hbf
`define LMDP_PWM_MIN_CODE    8'h40

// Extended battery control register field and reset, and the battery B copy reset
`define LMDP_EXT_EN_BIT      0
`define LMDP_EXT_RESET       1'b0
`define LMDP_BATT_B_RESET    8'h00

// Scales of the sense codes, per code step (all-ones is full scale)
`define LMDP_BATT_STEP_MV    376
`define LMDP_FEED_12_STEP_UA 319
`define LMDP_FEED_34_STEP_NA 37600
`define LMDP_FEED_56_STEP_UA 316

// Period step time and its cycle count at the core clock
`define LMDP_CLK_MHZ         50
`define LMDP_STEP_PS         61035
`define LMDP_STEP_CYC        ((`LMDP_STEP_PS * `LMDP_CLK_MHZ + 500000) / 1000000)

// Bus answers
`define LMDP_RESP_OKAY       2'h0
`define LMDP_RESP_SLVERR     2'h2

`endif

// ===== rtl/lmdp_pkg.sv
// Types and shared arithmetic of the line monitor bank.
// Assumes lmdp_defs.svh is on the include path.
`include "lmdp_defs.svh"

package lmdp_pkg;

  // Write channel progress of the bus slave
  typedef enum logic [1:0] {
    LMDP_WR_IDLE,
    LMDP_WR_ADDR,
    LMDP_WR_DATA,
    LMDP_WR_RESP
  } lmdp_wr_state_t;

  // Register index carried on the bus
  typedef logic [7:0] lmdp_idx_t;

  // Removes the extended battery offset from a feed current, floored at zero
  function automatic logic [7:0] lmdp_strip_offset(input logic [7:0] raw,
                                                   input logic [7:0] offset,
                                                   input logic       enable);
    logic [7:0] res;
    res = raw;
    if (enable) begin
      res = (raw > offset) ? 8'(raw - offset) : 8'h00;
    end
    return res;
  endfunction : lmdp_strip_offset

endpackage : lmdp_pkg

// ===== rtl/lmdp_sense_snap.sv
// Captures the measured battery and feed current codes every clock.
// Assumes the measurement codes arrive synchronous to aclk.
`timescale 1ns/100ps
`include "lmdp_defs.svh"

module lmdp_sense_snap (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       extended_battery_enable,
  input  wire logic [7:0] extended_battery_offset_current,
  input  wire logic [7:0] batt_a_in,
  input  wire logic [7:0] batt_b_in,
  input  wire logic [7:0] feed_one_in,
  input  wire logic [7:0] feed_two_in,
  input  wire logic [7:0] feed_three_in,
  input  wire logic [7:0] feed_four_in,
  input  wire logic [7:0] feed_five_in,
  input  wire logic [7:0] feed_six_in,
  output logic      [7:0] batt_a_ff,
  output logic      [7:0] batt_b_ff,
  output logic      [7:0] feed_one_ff,
  output logic      [7:0] feed_two_ff,
  output logic      [7:0] feed_three_ff,
  output logic      [7:0] feed_four_ff,
  output logic      [7:0] feed_five_ff,
  output logic      [7:0] feed_six_ff
);

  // Feed one and two with the extended battery share removed when asked
  wire logic [7:0] nxt_feed_one;
  wire logic [7:0] nxt_feed_two;

  assign nxt_feed_one = lmdp_pkg::lmdp_strip_offset(feed_one_in, extended_battery_offset_current,
                                                    extended_battery_enable);
  assign nxt_feed_two = lmdp_pkg::lmdp_strip_offset(feed_two_in, extended_battery_offset_current,
                                                    extended_battery_enable);

  // Real-time copies; no reset, so content is undefined until the first clock
  always_ff @(posedge aclk) begin
    batt_a_ff     <= batt_a_in;
    feed_one_ff   <= nxt_feed_one;
    feed_two_ff   <= nxt_feed_two;
    feed_three_ff <= feed_three_in;
    feed_four_ff  <= feed_four_in;
    feed_five_ff  <= feed_five_in;
    feed_six_ff   <= feed_six_in;
  end

  // Second battery copy has a defined zero after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      batt_b_ff <= `LMDP_BATT_B_RESET;
    end else begin
      batt_b_ff <= batt_b_in;
    end
  end

endmodule : lmdp_sense_snap

// ===== rtl/lmdp_pwm_timer.sv
// Converter period timer: one pulse per period of code times one step.
// Assumes the code never falls below the minimum, since bit 6 is forced.
`timescale 1ns/100ps
`include "lmdp_defs.svh"

module lmdp_pwm_timer (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] period_code,
  output logic            period_start_ff
);

  localparam logic [1:0] STEP_LAST = 2'(`LMDP_STEP_CYC - 1);

  logic [1:0] step_cnt_ff; // Cycles within one period step
  logic [7:0] code_cnt_ff; // Steps within one period
  wire  logic step_tick;   // One-cycle enable per step
  wire  logic period_end;  // Last step of the period

  assign step_tick  = (step_cnt_ff == STEP_LAST);
  assign period_end = step_tick && (code_cnt_ff >= 8'(period_code - 8'h01));

  // Step divider; the step is rounded to whole clock cycles, a small drift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_cnt_ff <= 2'h0;
    end else begin
      step_cnt_ff <= step_tick ? 2'h0 : 2'(step_cnt_ff + 2'h1);
    end
  end

  // Step counter; a code change takes effect at the latest next period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_cnt_ff     <= 8'h00;
      period_start_ff <= 1'b0;
    end else begin
      period_start_ff <= period_end;
      if (period_end) begin
        code_cnt_ff <= 8'h00;
      end else if (step_tick) begin
        code_cnt_ff <= 8'(code_cnt_ff + 8'h01);
      end
    end
  end

endmodule : lmdp_pwm_timer

// ===== verif/lmdp_chk.sv
// Checker of the line monitor bank: bus handshakes, read answers, period timer.
// Assumes it is bound to lmdp_regs and sees its ports only.
`timescale 1ns/100ps

module lmdp_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  converter_pwm_period,
  input wire logic        converter_period_start
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [9:0] rd_idx_ff;  // Index of the read in flight
  logic [9:0] gap_ff;     // Cycles since the last period pulse
  logic [7:0] code_ff;    // Effective code at the last pulse
  logic       seen_ff;    // A first pulse has been seen
  wire  [7:0] code_now = converter_pwm_period | 8'h40;
  wire  [9:0] want_gap = {2'h0, code_now} * 10'h003;
  // Only these indices answer OKAY; top address bits must be zero
  wire        mapped = (rd_idx_ff >= 10'h052 && rd_idx_ff <= 10'h059) ||
                       rd_idx_ff == 10'h05c || rd_idx_ff == 10'h05f;

  // Track read index and pulse spacing; a second pulse is needed before judging
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_idx_ff <= 10'h000;
      gap_ff    <= 10'h000;
      code_ff   <= 8'h00;
      seen_ff   <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_idx_ff <= s_axi_araddr[11:2];
      gap_ff <= converter_period_start ? 10'h001 : gap_ff + 10'h001;
      if (converter_period_start) begin
        code_ff <= code_now;
        seen_ff <= 1'b1;
      end
    end
  end

  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_rd_resp: assert property (s_axi_rvalid |-> s_axi_rresp == (mapped ? 2'h0 : 2'h2))
    else $error("wrong read response");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (mapped || s_axi_rdata == 32'h0))
    else $error("read data out of lane");
  a_pwm_bit6: assert property (s_axi_rvalid && rd_idx_ff == 10'h05c |-> s_axi_rdata[6])
    else $error("period bit six low");
  a_period_gap: assert property (converter_period_start && seen_ff && code_ff == code_now |-> gap_ff == want_gap)
    else $error("period length wrong");
  a_pulse_one: assert property (converter_period_start |=> !converter_period_start)
    else $error("period pulse too long");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready && !mapped);
  c_period: cover property (converter_period_start && seen_ff && code_now == 8'h40);
endmodule : lmdp_chk

bind lmdp_regs lmdp_chk i_chk (.*);

// ===== verif/lmdp_sense_model.sv
// Behavioural analog front end: samples the measured codes once per clock.
// Assumes the bench sets the codes; nothing here is reset, as on the real path.
`timescale 1ns/100ps

module lmdp_sense_model (
  input  wire logic        aclk,
  input  wire logic [63:0] codes,
  output logic      [7:0]  sense_ff [8]
);
  // Each lane is one converter result, refreshed every cycle like a live reading
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 8; i++) sense_ff[i] <= codes[8*i +: 8];
  end
endmodule : lmdp_sense_model

// ===== verif/tb.sv
// Self-checking bench of the line monitor bank over AXI4-Lite.
// Assumes lmdp_regs, lmdp_chk and lmdp_sense_model are compiled before it.
`timescale 1ns/100ps

module tb;
  logic        aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [63:0] codes;                // Front end inputs
  logic [7:0]  off;                  // Extended battery offset code
  logic [7:0]  sense [8];            // Model outputs
  logic [7:0]  pwm;
  logic        pstart, ext_en;
  logic [33:0] q [$];                // Expected {resp, data} of reads
  logic [1:0]  qb [$];               // Expected write responses
  int          miscompares, tests_run;
  logic [31:0] rng = 32'h5612bbf0;
  logic [7:0]  e;
  logic [7:0]  pw [4] = '{8'h00, 8'h3f, 8'h80, 8'hbf};

  lmdp_sense_model i_fe (.aclk(aclk), .codes(codes), .sense_ff(sense));

  lmdp_regs i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .batt_a_in(sense[0]), .batt_b_in(sense[1]), .feed_one_in(sense[2]), .feed_two_in(sense[3]),
    .feed_three_in(sense[4]), .feed_four_in(sense[5]), .feed_five_in(sense[6]), .feed_six_in(sense[7]),
    .extended_battery_offset_current(off),
    .converter_pwm_period(pwm), .converter_period_start(pstart), .extended_battery_enable(ext_en)
  );

  // Free running 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // Write one word; address and data offered together, bready held until the answer
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    qb.push_back(er);
    @(posedge aclk);
    awaddr  <= {idx, 2'h0};
    wdata   <= d;
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  // Read one word; the monitor compares the answer against the note left here
  task automatic rd(input logic [9:0] idx, input logic [33:0] ex);
    q.push_back(ex);
    @(posedge aclk);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  // Monitor: oldest note against each read answer and each write answer
  always @(posedge aclk) begin
    if (aresetn && rvalid && rready) check({rresp, rdata}, q.pop_front());
    if (aresetn && bvalid && bready) check(bresp, qb.pop_front());
  end

  // Watchdog sized well above the expected run of about 6000 cycles
  initial begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    test_done();
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    codes = 64'h0;
    off   = 8'h00;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(10'h05c, {2'h0, 32'hff});
    rd(10'h05f, {2'h0, 32'h0});
    // Sense codes: all zero, all ones, then random; offset stripping in later rounds
    for (int n = 0; n < 7; n++) begin
      if (n == 4) begin
        wr(10'h05f, 32'h1, 2'h0);
        @(posedge aclk);
        check(ext_en, 1'b1);
      end
      @(posedge aclk);
      rng = xs(rng);
      codes[31:0] <= (n == 0) ? 32'h0 : (n == 1) ? 32'hffffffff : rng;
      off <= rng[7:0];
      rng = xs(rng);
      codes[63:32] <= (n == 0) ? 32'h0 : (n == 1) ? 32'hffffffff : rng;
      repeat (6) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        e = codes[8*i +: 8];
        if (n >= 4 && (i == 2 || i == 3)) e = (e > off) ? e - off : 8'h00;
        rd(10'h052 + 10'(i), {2'h0, 24'h0, e});
      end
    end
    // Sense registers ignore writes; a second read sees the same live value
    wr(10'h054, 32'h5a, 2'h0);
    wr(10'h052, 32'ha5, 2'h0);
    rd(10'h052, {2'h0, 24'h0, codes[7:0]});
    rd(10'h054, {2'h0, 24'h0, (codes[23:16] > off) ? codes[23:16] - off : 8'h00});
    wr(10'h05f, 32'h0, 2'h0);
    @(posedge aclk);
    check(ext_en, 1'b0);
    // Period codes: lower range for a FET switch, upper for a bipolar one
    for (int k = 0; k < 4; k++) begin
      wr(10'h05c, {24'h0, pw[k]}, 2'h0);
      e = pw[k] | 8'h40;
      rd(10'h05c, {2'h0, 24'h0, e});
      check(pwm, e);
      repeat (9 * int'(e)) @(posedge aclk);
    end
    // Unmapped places, including nonzero top address bits
    rd(10'h05a, {2'h2, 32'h0});
    rd(10'h25c, {2'h2, 32'h0});
    wr(10'h05b, 32'h1, 2'h2);
    @(posedge aclk);
    check(q.size(), 0);
    check(qb.size(), 0);
    test_done();
  end
endmodule : tb
